// *** asirc_map.vh ***
// register map, field positions, reset values and timing for the rx channel 8 / rate block
`ifndef ASIRC_MAP_VH
`define ASIRC_MAP_VH
// register indices, byte address is four times the index
`define ASIRC_IDX_RX8_ROUTE 6'h2F
`define ASIRC_IDX_CLK_RATE 6'h32
`define ASIRC_IDX_STATUS 6'h3F
// rx channel 8 routing fields
`define ASIRC_RX8_SRC_HI 6
`define ASIRC_RX8_SRC_LO 5
`define ASIRC_RX8_SLOT_HI 4
`define ASIRC_RX8_SLOT_LO 0
`define ASIRC_RX8_SRC_RST 2'h0
`define ASIRC_RX8_SLOT_RST 5'h07
// source select codes
`define ASIRC_SRC_OFF 2'h0
`define ASIRC_SRC_DAC 2'h1
`define ASIRC_SRC_ADC_LOOP 2'h2
`define ASIRC_SRC_LINKED 2'h3
// clock rate config fields
`define ASIRC_RATE_HI 7
`define ASIRC_RATE_LO 2
`define ASIRC_TOL_BIT 1
`define ASIRC_CUSTOM_BIT 0
`define ASIRC_RATE_RST 6'h00
`define ASIRC_RATE_AUTO 6'h00
`define ASIRC_RATE_FIRST 6'h01
`define ASIRC_RATE_LAST 6'h28
// status fields
`define ASIRC_STAT_LOCK_BIT 6
// timing
`define ASIRC_CLK_HZ 20000000
`define ASIRC_TOL_TIGHT_PCT 1
`define ASIRC_TOL_WIDE_PCT 5
`define ASIRC_PERIOD_MAX 16'hFFFF
`endif

// *** asirc_rate_rom.v ***
// nominal rate and allowed window table for primary port rate codes
`timescale 1ns/10ps
module asirc_rate_rom (
    input wire clk_i,
    input wire [5:0] addr_i,
    output reg [19:0] nom_o,
    output reg [19:0] lo_o,
    output reg [19:0] hi_o
);
    always @(posedge clk_i) begin
        case (addr_i)
            6'd1: begin nom_o <= 20'd768000; lo_o <= 20'd670320; hi_o <= 20'd791040; end
            6'd2: begin nom_o <= 20'd614400; lo_o <= 20'd536256; hi_o <= 20'd632832; end
            6'd3: begin nom_o <= 20'd512000; lo_o <= 20'd446880; hi_o <= 20'd527360; end
            6'd4: begin nom_o <= 20'd438857; lo_o <= 20'd383040; hi_o <= 20'd452022; end
            6'd5: begin nom_o <= 20'd384000; lo_o <= 20'd335160; hi_o <= 20'd395520; end
            6'd6: begin nom_o <= 20'd341333; lo_o <= 20'd297920; hi_o <= 20'd351573; end
            6'd7: begin nom_o <= 20'd307200; lo_o <= 20'd268128; hi_o <= 20'd316416; end
            6'd8: begin nom_o <= 20'd256000; lo_o <= 20'd223440; hi_o <= 20'd263680; end
            6'd9: begin nom_o <= 20'd219429; lo_o <= 20'd191520; hi_o <= 20'd226011; end
            6'd10: begin nom_o <= 20'd192000; lo_o <= 20'd167580; hi_o <= 20'd197760; end
            6'd11: begin nom_o <= 20'd170667; lo_o <= 20'd148960; hi_o <= 20'd175786; end
            6'd12: begin nom_o <= 20'd153600; lo_o <= 20'd134064; hi_o <= 20'd158208; end
            6'd13: begin nom_o <= 20'd128000; lo_o <= 20'd111720; hi_o <= 20'd131840; end
            6'd14: begin nom_o <= 20'd109714; lo_o <= 20'd95760; hi_o <= 20'd113005; end
            6'd15: begin nom_o <= 20'd96000; lo_o <= 20'd83790; hi_o <= 20'd98880; end
            6'd16: begin nom_o <= 20'd85333; lo_o <= 20'd74480; hi_o <= 20'd87893; end
            6'd17: begin nom_o <= 20'd76800; lo_o <= 20'd67032; hi_o <= 20'd79104; end
            6'd18: begin nom_o <= 20'd64000; lo_o <= 20'd55860; hi_o <= 20'd65920; end
            6'd19: begin nom_o <= 20'd54857; lo_o <= 20'd47880; hi_o <= 20'd56502; end
            6'd20: begin nom_o <= 20'd48000; lo_o <= 20'd41895; hi_o <= 20'd49440; end
            6'd21: begin nom_o <= 20'd42667; lo_o <= 20'd37240; hi_o <= 20'd43946; end
            6'd22: begin nom_o <= 20'd38400; lo_o <= 20'd33516; hi_o <= 20'd39552; end
            6'd23: begin nom_o <= 20'd32000; lo_o <= 20'd27930; hi_o <= 20'd32960; end
            6'd24: begin nom_o <= 20'd27429; lo_o <= 20'd23940; hi_o <= 20'd28251; end
            6'd25: begin nom_o <= 20'd24000; lo_o <= 20'd20947; hi_o <= 20'd24720; end
            6'd26: begin nom_o <= 20'd21333; lo_o <= 20'd18620; hi_o <= 20'd21973; end
            6'd27: begin nom_o <= 20'd19200; lo_o <= 20'd16758; hi_o <= 20'd19776; end
            6'd28: begin nom_o <= 20'd16000; lo_o <= 20'd13965; hi_o <= 20'd16480; end
            6'd29: begin nom_o <= 20'd13714; lo_o <= 20'd11970; hi_o <= 20'd14125; end
            6'd30: begin nom_o <= 20'd12000; lo_o <= 20'd10473; hi_o <= 20'd12360; end
            6'd31: begin nom_o <= 20'd10667; lo_o <= 20'd9310; hi_o <= 20'd10986; end
            6'd32: begin nom_o <= 20'd9600; lo_o <= 20'd8379; hi_o <= 20'd9888; end
            6'd33: begin nom_o <= 20'd8000; lo_o <= 20'd6982; hi_o <= 20'd8240; end
            6'd34: begin nom_o <= 20'd6857; lo_o <= 20'd5985; hi_o <= 20'd7062; end
            6'd35: begin nom_o <= 20'd6000; lo_o <= 20'd5236; hi_o <= 20'd6180; end
            6'd36: begin nom_o <= 20'd5333; lo_o <= 20'd4655; hi_o <= 20'd5493; end
            6'd37: begin nom_o <= 20'd4800; lo_o <= 20'd4189; hi_o <= 20'd4944; end
            6'd38: begin nom_o <= 20'd4000; lo_o <= 20'd3491; hi_o <= 20'd4120; end
            6'd39: begin nom_o <= 20'd3429; lo_o <= 20'd2992; hi_o <= 20'd3531; end
            6'd40: begin nom_o <= 20'd3000; lo_o <= 20'd2618; hi_o <= 20'd3090; end
            default: begin nom_o <= 20'h0_0000; lo_o <= 20'h0_0000; hi_o <= 20'h0_0000; end
        endcase
    end
endmodule // asirc_rate_rom

// *** asirc_top.v ***
// rx channel 8 routing and primary port rate / clock mode registers over wishbone
`timescale 1ns/10ps
`include "asirc_map.vh"
module asirc_top #(
    parameter CLK_HZ = `ASIRC_CLK_HZ
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire fsync_i,
    output reg rx8_enable_o,
    output reg rx8_from_dac_o,
    output reg rx8_from_adc_loop_o,
    output reg rx8_from_linked_o,
    output reg [4:0] rx8_tdm_slot_o,
    output reg [3:0] rx8_half_slot_o,
    output reg rx8_right_half_o,
    output reg [5:0] rate_code_o,
    output reg rate_locked_o,
    output reg custom_clk_o
);
    localparam S_IDLE = 2'd0;
    localparam S_WAIT = 2'd1;
    localparam S_CHK = 2'd2;
    localparam [47:0] CLK_W = CLK_HZ;
    localparam [47:0] CLK_X100 = CLK_W * 48'd100;
    localparam [47:0] TOL_TIGHT = 48'd100 + `ASIRC_TOL_TIGHT_PCT;
    localparam [47:0] TOL_TIGHT_N = 48'd100 - `ASIRC_TOL_TIGHT_PCT;
    localparam [47:0] TOL_WIDE = 48'd100 + `ASIRC_TOL_WIDE_PCT;
    localparam [47:0] TOL_WIDE_N = 48'd100 - `ASIRC_TOL_WIDE_PCT;

    reg [1:0] src_reg;
    reg [4:0] slot_reg;
    reg [5:0] rate_reg;
    reg tol_reg;
    reg custom_reg;
    reg fs_meta_reg, fs_sync_reg, fs_prev_reg;
    reg [15:0] cnt_reg;
    reg seen_edge_reg;
    reg [15:0] period_reg;
    reg [1:0] state_reg;
    reg [5:0] addr_reg;
    reg [5:0] last_reg;
    reg [5:0] det_reg;
    reg lock_reg;
    wire [19:0] rom_nom, rom_lo, rom_hi;
    wire fs_rise;
    wire [47:0] p_w;
    wire [47:0] p_nom;
    wire [47:0] tol_hi, tol_lo;
    wire hit_fixed, hit_auto, hit;
    wire acc;
    wire [5:0] idx;
    wire auto_mode;
    wire rate_ok;
    wire [3:0] src_hot;

    function [3:0] src_onehot;
        input [1:0] s;
        begin
            case (s)
                `ASIRC_SRC_DAC: src_onehot = 4'h2;
                `ASIRC_SRC_ADC_LOOP: src_onehot = 4'h4;
                `ASIRC_SRC_LINKED: src_onehot = 4'h8;
                default: src_onehot = 4'h1;
            endcase
        end
    endfunction

    asirc_rate_rom u_rom (
        .clk_i(clk_i),
        .addr_i(addr_reg),
        .nom_o(rom_nom),
        .lo_o(rom_lo),
        .hi_o(rom_hi)
    );

    assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign idx = wb_adr_i[7:2];
    assign auto_mode = (rate_reg == `ASIRC_RATE_AUTO);
    assign rate_ok = auto_mode | (rate_reg <= `ASIRC_RATE_LAST);
    assign fs_rise = fs_sync_reg & ~fs_prev_reg;
    assign p_w = {32'h0000_0000, period_reg};
    assign p_nom = p_w * {28'h000_0000, rom_nom};
    assign tol_hi = tol_reg ? TOL_WIDE : TOL_TIGHT;
    assign tol_lo = tol_reg ? TOL_WIDE_N : TOL_TIGHT_N;
    // f in [lo,hi] is period*lo <= clk <= period*hi
    assign hit_fixed = (p_w * {28'h000_0000, rom_lo} <= CLK_W)
        && (p_w * {28'h000_0000, rom_hi} >= CLK_W);
    assign hit_auto = (p_nom * tol_lo <= CLK_X100) && (p_nom * tol_hi >= CLK_X100);
    assign hit = auto_mode ? hit_auto : hit_fixed;
    assign src_hot = src_onehot(src_reg);

    // wishbone slave, one wait state
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            src_reg <= `ASIRC_RX8_SRC_RST;
            slot_reg <= `ASIRC_RX8_SLOT_RST;
            rate_reg <= `ASIRC_RATE_RST;
            tol_reg <= 1'b0;
            custom_reg <= 1'b0;
        end else begin
            wb_ack_o <= acc;
            if (acc && wb_we_i && wb_sel_i[0]) begin
                case (idx)
                    `ASIRC_IDX_RX8_ROUTE: begin
                        src_reg <= wb_dat_i[`ASIRC_RX8_SRC_HI:`ASIRC_RX8_SRC_LO];
                        slot_reg <= wb_dat_i[`ASIRC_RX8_SLOT_HI:`ASIRC_RX8_SLOT_LO];
                    end
                    `ASIRC_IDX_CLK_RATE: begin
                        rate_reg <= wb_dat_i[`ASIRC_RATE_HI:`ASIRC_RATE_LO];
                        tol_reg <= wb_dat_i[`ASIRC_TOL_BIT];
                        custom_reg <= wb_dat_i[`ASIRC_CUSTOM_BIT];
                    end
                    default: begin
                    end
                endcase
            end
            if (acc && !wb_we_i) begin
                case (idx)
                    `ASIRC_IDX_RX8_ROUTE: wb_dat_o <= {24'h00_0000, 1'b0, src_reg, slot_reg};
                    `ASIRC_IDX_CLK_RATE: wb_dat_o <= {24'h00_0000, rate_reg, tol_reg, custom_reg};
                    `ASIRC_IDX_STATUS: wb_dat_o <= {24'h00_0000, 1'b0, lock_reg, det_reg};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // frame sync period measurement
    always @(posedge clk_i) begin
        if (rst_i) begin
            fs_meta_reg <= 1'b0;
            fs_sync_reg <= 1'b0;
            fs_prev_reg <= 1'b0;
            cnt_reg <= 16'h0000;
            seen_edge_reg <= 1'b0;
            period_reg <= 16'h0000;
        end else begin
            fs_meta_reg <= fsync_i;
            fs_sync_reg <= fs_meta_reg;
            fs_prev_reg <= fs_sync_reg;
            if (fs_rise) begin
                cnt_reg <= 16'h0001;
                seen_edge_reg <= 1'b1;
                if (seen_edge_reg && state_reg == S_IDLE)
                    period_reg <= cnt_reg;
            end else if (cnt_reg != `ASIRC_PERIOD_MAX) begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
        end
    end

    // rate search: codes 1 to 40 in order, stopping at the first hit, in auto mode; the programmed one otherwise
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= S_IDLE;
            addr_reg <= `ASIRC_RATE_FIRST;
            last_reg <= `ASIRC_RATE_FIRST;
            det_reg <= 6'h00;
            lock_reg <= 1'b0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (fs_rise && seen_edge_reg) begin
                        if (!rate_ok || cnt_reg == `ASIRC_PERIOD_MAX) begin
                            lock_reg <= 1'b0;
                            det_reg <= 6'h00;
                        end else begin
                            addr_reg <= auto_mode ? `ASIRC_RATE_FIRST : rate_reg;
                            last_reg <= auto_mode ? `ASIRC_RATE_LAST : rate_reg;
                            state_reg <= S_WAIT;
                        end
                    end
                end
                S_WAIT: state_reg <= S_CHK;
                S_CHK: begin
                    if (hit) begin
                        det_reg <= addr_reg;
                        lock_reg <= 1'b1;
                        state_reg <= S_IDLE;
                    end else if (addr_reg == last_reg) begin
                        det_reg <= 6'h00;
                        lock_reg <= 1'b0;
                        state_reg <= S_IDLE;
                    end else begin
                        addr_reg <= addr_reg + 6'h01;
                        state_reg <= S_WAIT;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // registered routing and clock outputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx8_enable_o <= 1'b0;
            rx8_from_dac_o <= 1'b0;
            rx8_from_adc_loop_o <= 1'b0;
            rx8_from_linked_o <= 1'b0;
            rx8_tdm_slot_o <= `ASIRC_RX8_SLOT_RST;
            rx8_half_slot_o <= 4'h7;
            rx8_right_half_o <= 1'b0;
            rate_code_o <= 6'h00;
            rate_locked_o <= 1'b0;
            custom_clk_o <= 1'b0;
        end else begin
            rx8_enable_o <= ~src_hot[0];
            rx8_from_dac_o <= src_hot[1];
            rx8_from_adc_loop_o <= src_hot[2];
            rx8_from_linked_o <= src_hot[3];
            rx8_tdm_slot_o <= slot_reg;
            rx8_half_slot_o <= slot_reg[3:0];
            rx8_right_half_o <= slot_reg[4];
            rate_code_o <= auto_mode ? det_reg : rate_reg;
            rate_locked_o <= lock_reg;
            custom_clk_o <= custom_reg;
        end
    end
endmodule // asirc_top

// *** asirc_top_props.sv ***
// concurrent checks on the rx channel 8 routing and clock rate register block
`timescale 1ns/10ps
`include "asirc_map.vh"
module asirc_top_props #(
    parameter CLK_HZ = `ASIRC_CLK_HZ
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire fsync_i,
    input wire rx8_enable_o,
    input wire rx8_from_dac_o,
    input wire rx8_from_adc_loop_o,
    input wire rx8_from_linked_o,
    input wire [4:0] rx8_tdm_slot_o,
    input wire [3:0] rx8_half_slot_o,
    input wire rx8_right_half_o,
    input wire [5:0] rate_code_o,
    input wire rate_locked_o,
    input wire custom_clk_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_rt = tk & wb_we_i & wb_sel_i[0] & (wb_adr_i[7:2] == `ASIRC_IDX_RX8_ROUTE);
    wire wr_ck = tk & wb_we_i & wb_sel_i[0] & (wb_adr_i[7:2] == `ASIRC_IDX_CLK_RATE);
    wire rd_rt = tk & ~wb_we_i & (wb_adr_i[7:2] == `ASIRC_IDX_RX8_ROUTE);
    chk_ack_once: assert property (tk |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse one cycle after request");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    chk_rsv_read: assert property (rd_rt |=> wb_dat_o[31:7] == 25'h000_0000)
        else $error("reserved routing bit reads nonzero");
    chk_src_decode: assert property (rx8_enable_o == (rx8_from_dac_o | rx8_from_adc_loop_o
        | rx8_from_linked_o) && $onehot0({rx8_from_dac_o, rx8_from_adc_loop_o, rx8_from_linked_o}))
        else $error("source flags inconsistent");
    chk_half_slot: assert property ({rx8_right_half_o, rx8_half_slot_o} == rx8_tdm_slot_o)
        else $error("half-frame slot mismatch");
    chk_slot_write: assert property (wr_rt |-> ##2 rx8_tdm_slot_o == $past(wb_dat_i[4:0], 2)
        && rx8_from_linked_o == ($past(wb_dat_i[6:5], 2) == 2'h3))
        else $error("routing write not reflected");
    chk_rst_route: assert property ($fell(rst_i) |-> rx8_tdm_slot_o == 5'h07 && !rx8_enable_o)
        else $error("routing outputs wrong after reset");
    chk_rst_rate: assert property ($fell(rst_i) |-> rate_code_o == 6'h00 && !custom_clk_o)
        else $error("rate outputs wrong after reset");
    chk_custom_wr: assert property (wr_ck |-> ##2 custom_clk_o == $past(wb_dat_i[0], 2))
        else $error("custom clock flag not updated");
    chk_rate_fixed: assert property (wr_ck && wb_dat_i[7:2] != 6'h00
        |-> ##2 rate_code_o == $past(wb_dat_i[7:2], 2))
        else $error("fixed rate code not applied");
endmodule // asirc_top_props
bind asirc_top asirc_top_props #(.CLK_HZ(CLK_HZ)) props_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .fsync_i(fsync_i), .rx8_enable_o(rx8_enable_o), .rx8_from_dac_o(rx8_from_dac_o),
    .rx8_from_adc_loop_o(rx8_from_adc_loop_o), .rx8_from_linked_o(rx8_from_linked_o),
    .rx8_tdm_slot_o(rx8_tdm_slot_o), .rx8_half_slot_o(rx8_half_slot_o),
    .rx8_right_half_o(rx8_right_half_o), .rate_code_o(rate_code_o),
    .rate_locked_o(rate_locked_o), .custom_clk_o(custom_clk_o));

// *** testbench.sv ***
// self-checking bench for the rx channel 8 routing and clock rate register block
`timescale 1ns/10ps
`include "asirc_map.vh"
module testbench;
    localparam logic [7:0] A_RT = {`ASIRC_IDX_RX8_ROUTE, 2'b00};
    localparam logic [7:0] A_CK = {`ASIRC_IDX_CLK_RATE, 2'b00};
    localparam logic [7:0] A_ST = {`ASIRC_IDX_STATUS, 2'b00};
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic fsync_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000, rd;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, rx8_enable_o, rx8_from_dac_o, rx8_from_adc_loop_o, rx8_from_linked_o;
    wire [4:0] rx8_tdm_slot_o;
    wire [3:0] rx8_half_slot_o;
    wire rx8_right_half_o, rate_locked_o, custom_clk_o;
    wire [5:0] rate_code_o;
    int n_fail = 0, cmp_count = 0, cyc_cnt = 0, fs_per = 0, fs_cnt = 0;
    logic [7:0] d;
    logic [5:0] code;
    asirc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fsync_i(fsync_i),
        .rx8_enable_o(rx8_enable_o), .rx8_from_dac_o(rx8_from_dac_o),
        .rx8_from_adc_loop_o(rx8_from_adc_loop_o), .rx8_from_linked_o(rx8_from_linked_o),
        .rx8_tdm_slot_o(rx8_tdm_slot_o), .rx8_half_slot_o(rx8_half_slot_o),
        .rx8_right_half_o(rx8_right_half_o), .rate_code_o(rate_code_o),
        .rate_locked_o(rate_locked_o), .custom_clk_o(custom_clk_o));
    always #25 clk_i = ~clk_i;
    // frame sync source, square wave of fs_per clocks
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            n_fail++;
            summarize();
        end
        fs_cnt <= (fs_per == 0 || fs_cnt >= fs_per - 1) ? 0 : fs_cnt + 1;
        fsync_i <= (fs_per != 0) && (fs_cnt < fs_per / 2);
    end
    task automatic summarize();
        if (n_fail == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // classic single wishbone cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dw,
            input logic [3:0] s);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= dw;
        wb_sel_i <= s;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    function automatic logic [31:0] route_exp(input logic [7:0] v);
        return 32'({v[6:5] != 2'h0, v[6:5] == 2'h1, v[6:5] == 2'h2, v[6:5] == 2'h3,
            v[4:0], v[3:0], v[4]});
    endfunction
    wire [31:0] route_out = 32'({rx8_enable_o, rx8_from_dac_o, rx8_from_adc_loop_o,
        rx8_from_linked_o, rx8_tdm_slot_o, rx8_half_slot_o, rx8_right_half_o});
    task automatic reset_check(input int n);
        rst_i <= 1'b1;
        repeat (n) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, A_RT, 32'h0000_0000, 4'hF);
        chk(rd, 32'h0000_0007, "route reset");
        chk(route_out, route_exp(8'h07), "route outputs reset");
        wb(1'b0, A_CK, 32'h0000_0000, 4'hF);
        chk(rd, 32'h0000_0000, "clock reg reset");
    endtask
    task automatic wait_fs(input int n);
        repeat (n) @(posedge clk_i);
        wb(1'b0, A_ST, 32'h0000_0000, 4'hF);
    endtask
    initial begin
        void'($urandom(32));
        reset_check(12);
        for (int i = 0; i < 16; i++) begin
            d = 8'($urandom);
            d[6:5] = i[1:0];
            d[7] = 1'b0;
            if (i < 8)
                d[4:0] = (i < 4) ? {i[1], {4{i[0]}}} : {i[0], 4'(2 + $urandom % 13)};
            wb(1'b1, A_RT, {24'($urandom), d}, 4'hF);
            wb(1'b0, A_RT, 32'h0000_0000, 4'hF);
            chk(rd, {24'h00_0000, 1'b0, d[6:0]}, "route readback");
            repeat (2) @(posedge clk_i);
            chk(route_out, route_exp(d), "route outputs");
        end
        wb(1'b1, A_RT, 32'h0000_007F, 4'hE);
        wb(1'b0, A_RT, 32'h0000_0000, 4'hF);
        chk(rd, {24'h00_0000, 1'b0, d[6:0]}, "write without sel0 ignored");
        wb(1'b0, 8'h00, 32'h0000_0000, 4'hF);
        chk(rd, 32'h0000_0000, "unmapped read");
        for (int i = 0; i < 8; i++) begin
            code = (i == 0) ? 6'h01 : (i == 1) ? 6'h28 : 6'(1 + $urandom % 40);
            d = {code, 2'($urandom)};
            wb(1'b1, A_CK, 32'(d), 4'hF);
            wb(1'b0, A_CK, 32'h0000_0000, 4'hF);
            chk(rd, 32'(d), "clock reg readback");
            repeat (2) @(posedge clk_i);
            chk(32'({rate_code_o, custom_clk_o}), 32'({code, d[0]}), "fixed rate");
        end
        wb(1'b1, A_CK, 32'h0000_0000, 4'hF);
        fs_per = 417;
        wait_fs(2500);
        chk(rd, 32'h0000_0054, "auto detect 48k tight");
        chk(32'({rate_locked_o, rate_code_o}), 32'h0000_0054, "auto outputs");
        fs_per = 404;
        wait_fs(2500);
        chk(32'(rate_locked_o), 32'h0000_0000, "3 percent off refused tight");
        wb(1'b1, A_CK, 32'h0000_0002, 4'hF);
        wait_fs(2500);
        chk(rd, 32'h0000_0054, "3 percent off accepted wide");
        wb(1'b1, A_CK, 32'h0000_0050, 4'hF);
        wait_fs(1000);
        chk(rd, 32'h0000_0000, "fixed 48k window refuses 49.5k");
        chk(32'({rate_locked_o, rate_code_o}), 32'h0000_0014, "fixed code kept unlocked");
        fs_per = 417;
        wait_fs(1000);
        chk(rd, 32'h0000_0054, "fixed 48k window accepts");
        fs_per = 0;
        reset_check(3);
        summarize();
    end
endmodule // testbench
